// file: rtl/lpdmr_defs.vh
// Summary of operation
// - clock stop offered only after initialization
// - load command with banks zero loads register
// - bank bits one-zero select extended register
// - field layout: length, type, latency, mode
// - length codes 1..4 give 2,4,8,16
// - latency codes 2 and 3 only
// - mode bits all zero mean normal
// - burst wraps inside length-sized column block
// - type bit: sequential count or xor interleave
// - one length governs reads and writes
// - first read data latency minus one clocks
//
// Purpose: constants for the mode register and burst sequencing block
// Assumes: commands sampled at mclk, active-low command pins
// Notes:   definitions only
`ifndef LPDMR_DEFS_VH
`define LPDMR_DEFS_VH
// ==========================================================
// command encodings {cs_n, ras_n, cas_n, we_n}
`define LPDMR_CMD_LOAD     4'h0
`define LPDMR_CMD_REFRESH  4'h1
`define LPDMR_CMD_PRECH    4'h2
`define LPDMR_CMD_ACTIVE   4'h3
`define LPDMR_CMD_WRITE    4'h4
`define LPDMR_CMD_READ     4'h5
// ==========================================================
// bank selects
`define LPDMR_BA_STD       2'h0
`define LPDMR_BA_EXT       2'h2
// ==========================================================
// field layout
`define LPDMR_BL_HI        2
`define LPDMR_BL_LO        0
`define LPDMR_BT_BIT       3
`define LPDMR_CL_HI        6
`define LPDMR_CL_LO        4
`define LPDMR_OM_HI        12
`define LPDMR_OM_LO        7
`define LPDMR_OM_NORMAL    6'h00
`define LPDMR_BL_2         3'h1
`define LPDMR_BL_4         3'h2
`define LPDMR_BL_8         3'h3
`define LPDMR_BL_16        3'h4
`define LPDMR_CL_2         3'h2
`define LPDMR_CL_3         3'h3
`define LPDMR_MR_RESET     13'h0000
`define LPDMR_PRECH_ALL    10
`define LPDMR_REFRESH_NEED 2'h2
// column split: block base above, start index below
`define LPDMR_COL_HI       9
`define LPDMR_BASE_LO      4
`define LPDMR_START_HI     3
// pre-beat wait loaded on a read, per latency code
`define LPDMR_LAT_WAIT_3   2'h2
`define LPDMR_LAT_WAIT_2   2'h1
`endif

// file: rtl/lpdmr_burst_addr.v
// Purpose: column offset of one burst beat
// Assumes: start and beat are 4-bit indices
// Notes:   combinational
`timescale 1ns/1ps
`default_nettype none
module lpdmr_burst_addr (
    input  wire [3:0] start,
    input  wire [3:0] beat,
    input  wire [3:0] len_mask,
    input  wire       order_select_bit,
    output wire [3:0] offset
);
    // ==========================================================
    // order
    wire [3:0] seq_sum;
    wire [3:0] raw;
    assign seq_sum = start + beat;
    assign raw     = order_select_bit ? (start ^ beat) : seq_sum;
    // high bits keep start so the beat never leaves the block
    assign offset  = (raw & len_mask) | (start & ~len_mask);
endmodule
`default_nettype wire

// file: rtl/lpdmr_core.v
// Purpose: mode register load, init tracking and burst column sequencing
// Assumes: inputs synchronous to mclk; controller keeps its own timing
// Notes:   reserved codes are recorded but flagged; reserved length and latency codes act as 2
`timescale 1ns/1ps
`default_nettype none
`include "lpdmr_defs.vh"
module lpdmr_core (
    input  wire        mclk,
    input  wire        rstn,
    input  wire        cs_n,
    input  wire        ras_n,
    input  wire        cas_n,
    input  wire        we_n,
    input  wire [1:0]  ba,
    input  wire [12:0] addr,
    output reg  [12:0] burst_latency_mode_config,
    output reg  [12:0] ext_mode_config,
    output reg         init_done,
    output reg         clock_stop_allowed,
    output reg         normal_mode,
    output reg         config_error,
    output reg         burst_active,
    output reg         burst_is_write,
    output reg  [9:0]  burst_col,
    output reg         read_data_valid
);
    // ==========================================================
    // command decode
    wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
    wire is_load  = (cmd == `LPDMR_CMD_LOAD);
    wire is_ref   = (cmd == `LPDMR_CMD_REFRESH);
    wire is_rd    = (cmd == `LPDMR_CMD_READ);
    wire is_wr    = (cmd == `LPDMR_CMD_WRITE);
    wire [2:0] burst_count_setting = burst_latency_mode_config[`LPDMR_BL_HI:`LPDMR_BL_LO];
    wire [2:0] read_delay_setting  = burst_latency_mode_config[`LPDMR_CL_HI:`LPDMR_CL_LO];
    wire order_select_bit          = burst_latency_mode_config[`LPDMR_BT_BIT];
    // ==========================================================
    // init progress
    reg std_loaded;
    reg ext_loaded;
    reg [1:0] ref_count;
    wire seq_complete = std_loaded & ext_loaded & (ref_count == `LPDMR_REFRESH_NEED);
    always @(posedge mclk) begin
        if (!rstn) begin
            std_loaded <= 1'b0;
            ext_loaded <= 1'b0;
            ref_count  <= 2'h0;
            init_done  <= 1'b0;
            clock_stop_allowed <= 1'b0;
            burst_latency_mode_config <= `LPDMR_MR_RESET;
            ext_mode_config <= `LPDMR_MR_RESET;
        end else begin
            if (is_load && ba == `LPDMR_BA_STD) begin
                burst_latency_mode_config <= addr;
                std_loaded <= 1'b1;
            end
            if (is_load && ba == `LPDMR_BA_EXT) begin
                ext_mode_config <= addr;
                ext_loaded <= 1'b1;
            end
            if (is_ref && ref_count != `LPDMR_REFRESH_NEED)
                ref_count <= ref_count + 2'h1;
            if (seq_complete)
                init_done <= 1'b1;
            clock_stop_allowed <= seq_complete | init_done;
        end
    end
    // ==========================================================
    // mode decode
    reg [4:0] len;
    reg [3:0] len_mask;
    reg       bl_ok;
    always @* begin
        bl_ok = 1'b1;
        case (burst_count_setting)
            `LPDMR_BL_2:  begin len = 5'h02; len_mask = 4'h1; end
            `LPDMR_BL_4:  begin len = 5'h04; len_mask = 4'h3; end
            `LPDMR_BL_8:  begin len = 5'h08; len_mask = 4'h7; end
            `LPDMR_BL_16: begin len = 5'h10; len_mask = 4'hF; end
            default:      begin len = 5'h02; len_mask = 4'h1; bl_ok = 1'b0; end
        endcase
    end
    wire cl_ok = (read_delay_setting == `LPDMR_CL_2) | (read_delay_setting == `LPDMR_CL_3);
    wire om_ok = (burst_latency_mode_config[`LPDMR_OM_HI:`LPDMR_OM_LO] == `LPDMR_OM_NORMAL);
    always @(posedge mclk) begin
        if (!rstn) begin
            normal_mode  <= 1'b0;
            config_error <= 1'b0;
        end else begin
            normal_mode  <= om_ok;
            config_error <= std_loaded & ~(bl_ok & cl_ok & om_ok);
        end
    end
    // ==========================================================
    // burst sequencer, length shared by reads and writes
    reg  [5:0] col_base;
    reg  [3:0] col_start;
    reg  [3:0] beat;
    reg  [1:0] lat_cnt;
    wire [3:0] offset;
    wire [3:0] u_next_offset;
    lpdmr_burst_addr u_addr (
        .start            (col_start),
        .beat             (beat),
        .len_mask         (len_mask),
        .order_select_bit (order_select_bit),
        .offset           (offset)
    );
    // latency 2 gives first data one clock later, latency 3 two clocks
    wire [1:0] lat_load = (read_delay_setting == `LPDMR_CL_3) ? `LPDMR_LAT_WAIT_3
                                                              : `LPDMR_LAT_WAIT_2;
    wire last_beat = ({1'b0, beat} == len - 5'h01);
    wire lat_wait  = (lat_cnt != 2'h0);
    always @(posedge mclk) begin
        if (!rstn) begin
            burst_active    <= 1'b0;
            burst_is_write  <= 1'b0;
            burst_col       <= 10'h000;
            read_data_valid <= 1'b0;
            col_base  <= 6'h00;
            col_start <= 4'h0;
            beat      <= 4'h0;
            lat_cnt   <= 2'h0;
        end else if ((is_rd || is_wr) && init_done) begin
            // a new command truncates any burst in flight
            col_base  <= addr[`LPDMR_COL_HI:`LPDMR_BASE_LO];
            col_start <= addr[`LPDMR_START_HI:0];
            beat      <= 4'h0;
            burst_is_write  <= is_wr;
            lat_cnt   <= is_rd ? lat_load : 2'h0;
            burst_active    <= is_wr;
            read_data_valid <= 1'b0;
            burst_col <= addr[`LPDMR_COL_HI:0];
        end else if (lat_wait) begin
            lat_cnt <= lat_cnt - 2'h1;
            if (lat_cnt == 2'h1) begin
                burst_active    <= 1'b1;
                read_data_valid <= 1'b1;
                burst_col <= {col_base, offset};
            end
        end else if (burst_active) begin
            if (last_beat) begin
                burst_active    <= 1'b0;
                read_data_valid <= 1'b0;
            end else begin
                beat <= beat + 4'h1;
                burst_col <= {col_base, u_next_offset};
            end
        end
    end
    lpdmr_burst_addr u_next (
        .start            (col_start),
        .beat             (beat + 4'h1),
        .len_mask         (len_mask),
        .order_select_bit (order_select_bit),
        .offset           (u_next_offset)
    );
endmodule
`default_nettype wire

// file: verification/lpdmr_ctrl_model.sv
// Purpose: controller model driving commands
// Assumes: clock enable held high
// Notes:   startup wait shortened
`timescale 1ns/1ps
`default_nettype none
module lpdmr_ctrl_model #(
    parameter int WAIT = 20
) (
    input  wire logic        mclk,
    output var  logic        cs_n = 1'b1,
    output var  logic        ras_n = 1'b1,
    output var  logic        cas_n = 1'b1,
    output var  logic        we_n = 1'b1,
    output var  logic [1:0]  ba = 2'h0,
    output var  logic [12:0] addr = 13'h0000
);
    // ==========================================================
    // one command, then nops; address toggles so stale values show
    task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                         input int gap);
        @(posedge mclk);
        {cs_n, ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
        repeat (gap) begin
            @(posedge mclk);
            {cs_n, ras_n, cas_n, we_n} <= 4'h7;
            addr <= ~addr;
        end
    endtask
    task automatic init_seq(input logic [12:0] m, input logic [12:0] e);
        issue(4'h7, 2'h0, 13'h0000, WAIT);
        issue(4'h2, 2'h0, 13'h0400, 3);
        issue(4'h1, 2'h0, 13'h0000, 4);
        issue(4'h0, 2'h0, m, 2);
        issue(4'h0, 2'h2, e, 2);
        issue(4'h1, 2'h0, 13'h0000, 4);
    endtask
endmodule
`default_nettype wire

// file: verification/lpdmr_core_properties.sv
// Purpose: checker bound to lpdmr_core
// Assumes: bench keeps bursts apart
// Notes:   ports grouped to save space
`timescale 1ns/1ps
`default_nettype none
module lpdmr_core_properties (
    input wire logic        mclk, rstn, cs_n, ras_n, cas_n, we_n, init_done,
    input wire logic        clock_stop_allowed, normal_mode, burst_active, read_data_valid,
    input wire logic [1:0]  ba,
    input wire logic [9:0]  burst_col,
    input wire logic [12:0] addr, burst_latency_mode_config, ext_mode_config
);
    wire [3:0]  cmd = {cs_n, ras_n, cas_n, we_n};
    wire        ld  = cmd == 4'h0;
    wire        std = ld && ba == 2'h0;
    wire        rd  = cmd == 4'h5 && init_done;
    wire        dv  = read_data_valid;
    wire [9:0]  bc  = burst_col;
    wire [9:0]  col = addr[9:0];
    wire [12:0] mr  = burst_latency_mode_config;
    wire [2:0]  lat = mr[6:4];
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // properties
    chk_std_load: assert property (std |=> mr == $past(addr))
        else $error("std load lost");
    chk_ext_load: assert property (ld && ba == 2'h2 |=> ext_mode_config == $past(addr))
        else $error("ext load lost");
    chk_ext_apart: assert property (ld && ba == 2'h2 |=> $stable(mr))
        else $error("ext load hit std");
    chk_stop_gate: assert property (clock_stop_allowed == init_done)
        else $error("clock stop gate");
    chk_mode_flag: assert property (std |=> ##1 normal_mode == (mr[12:7] == 6'h00))
        else $error("mode flag");
    chk_lat_three: assert property (rd && lat == 3'h3 |-> ##3 dv && bc == $past(col, 3))
        else $error("latency three");
    chk_lat_two: assert property (rd && lat == 3'h2 |-> ##2 dv && bc == $past(col, 2))
        else $error("latency two");
    chk_wr_start: assert property (cmd == 4'h4 && init_done |=> burst_active && bc == $past(col))
        else $error("write start");
endmodule
bind lpdmr_core lpdmr_core_properties u_props (.*);
`default_nettype wire

// file: verification/lpdmr_core_tb_top.sv
// Purpose: bench for lpdmr_core
// Assumes: model drives all commands
// Notes:   random columns and types
`timescale 1ns/1ps
`default_nettype none
module lpdmr_core_tb_top;
    logic        mclk, rstn, cs_n, ras_n, cas_n, we_n, init_done, clock_stop_allowed;
    logic        normal_mode, config_error, burst_active, burst_is_write, read_data_valid;
    logic [1:0]  ba;
    logic [2:0]  bl;
    logic [7:0]  lfsr, r;
    logic [9:0]  burst_col;
    logic [12:0] addr, burst_latency_mode_config, ext_mode_config, code;
    int          fails, num_checks;
    lpdmr_ctrl_model ctl (.*);
    lpdmr_core dut (.*);
    function automatic logic [7:0] next_lfsr(input logic [7:0] v);
        next_lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic logic [9:0] exp_col(input logic [9:0] s, input int i, input int n,
                                           input logic t);
        logic [9:0] m;
        m = 10'(n - 1);
        exp_col = (s & ~m) | ((t ? s ^ 10'(i) : s + 10'(i)) & m);
    endfunction
    task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ==========================================================
    // one access, every beat compared
    task automatic access(input logic [3:0] c, input logic [9:0] s, input int lat, input int n,
                          input logic t);
        ctl.issue(c, 2'h0, {3'h0, s}, 1);
        repeat (lat - 1) @(posedge mclk);
        #1;
        for (int i = 0; i < n; i++) begin
            check("column", burst_col, exp_col(s, i, n, t));
            check("valid", read_data_valid, c == 4'h5);
            check("type", burst_is_write, c == 4'h4);
            @(posedge mclk);
            #1;
        end
        check("end", burst_active, 1'b0);
    endtask
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        #20000;
        fails++;
        give_verdict();
    end
    initial begin
        rstn = 1'b0;
        fails = 0;
        num_checks = 0;
        lfsr = 8'h3D;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        check("reset", burst_latency_mode_config, 13'h0000);
        ctl.issue(4'h5, 2'h0, 13'h0005, 4);
        check("early", burst_active, 1'b0);
        ctl.init_seq(13'h0032, 13'h0000);
        #1;
        check("init", init_done, 1'b1);
        check("stop", clock_stop_allowed, 1'b1);
        check("ext", ext_mode_config, 13'h0000);
        ctl.issue(4'h0, 2'h0, 13'h0085, 2);
        #1;
        check("reserved", config_error, 1'b1);
        check("test mode", normal_mode, 1'b0);
        // read or write by index so both latencies are met
        for (int i = 0; i < 8; i++) begin
            r = lfsr;
            lfsr = next_lfsr(lfsr);
            bl = {1'b0, r[2:1]} + 3'h1;
            code = {6'h00, i[2] ? 3'h3 : 3'h2, r[0], bl};
            ctl.issue(4'h0, 2'h0, code, 2);
            #1;
            check("mode", burst_latency_mode_config, code);
            check("error", config_error, 1'b0);
            access(i[0] ? 4'h5 : 4'h4, {lfsr, r[7:6]}, i[0] ? (i[2] ? 3 : 2) : 1, 2 << (bl - 1),
                   r[0]);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
